/* src/fsbs_pkg.sv */
// shared constants and types of the forced stop brake sequencer
package fsbs_pkg;

  // register byte offsets
  localparam logic [7:0]  FSBS_CTRL_OFS      = 8'h00;
  localparam logic [7:0]  FSBS_DECEL_OFS     = 8'h04;
  localparam logic [7:0]  FSBS_ZSPD_OFS      = 8'h08;
  localparam logic [7:0]  FSBS_DELAY_OFS     = 8'h0c;
  localparam logic [7:0]  FSBS_COMP_OFS      = 8'h10;
  localparam logic [7:0]  FSBS_STATUS_OFS    = 8'h14;
  localparam logic [7:0]  FSBS_SPEED_OFS     = 8'h18;

  // control register fields
  localparam int          FSBS_CTRL_TORQUE   = 0;
  localparam int          FSBS_CTRL_MODE_LSB = 12;
  localparam logic [3:0]  FSBS_MODE_DECEL    = 4'h2;
  localparam logic [3:0]  FSBS_MODE_NODECEL  = 4'h0;

  // status register fields
  localparam int          FSBS_ST_STOERR     = 0;
  localparam int          FSBS_ST_ZERO       = 1;
  localparam int          FSBS_ST_WARN       = 2;
  localparam int          FSBS_ST_STATE_LSB  = 4;

  // reset values
  localparam logic [15:0] FSBS_CTRL_RST      = 16'h2000;
  localparam logic [15:0] FSBS_DECEL_RST     = 16'h0064;
  localparam logic [15:0] FSBS_ZSPD_RST      = 16'h0032;
  localparam logic [15:0] FSBS_DELAY_RST     = 16'h0000;
  localparam logic [15:0] FSBS_COMP_RST      = 16'h0000;

  // zero speed switches off this far above its threshold (r/min)
  localparam logic [15:0] FSBS_ZSPD_HYST     = 16'h0014;
  // speed that the deceleration time constant refers to (r/min)
  localparam logic [15:0] FSBS_RATED_SPEED   = 16'h0bb8;

  // timing: clock period and one millisecond, both in ns
  localparam int          FSBS_CLK_NS        = 4;
  localparam int          FSBS_MS_NS         = 1000000;
  localparam int          FSBS_CYC_PER_MS    = FSBS_MS_NS / FSBS_CLK_NS;

  localparam logic [1:0]  FSBS_HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    FSBS_RUN  = 3'b000,
    FSBS_RAMP = 3'b001,
    FSBS_LIFT = 3'b010,
    FSBS_HOLD = 3'b011,
    FSBS_SHUT = 3'b100
  } fsbs_state_type;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } fsbs_ahb_req_type;

  typedef struct packed {
    logic        brake_interlock_output;
    logic        base_power_on;
    logic        dynamic_brake_on;
    logic        forced_stop_warning;
    logic        lift_request;
  } fsbs_drive_type;

endpackage : fsbs_pkg

/* src/fsbs_sequencer.sv */
// forced stop brake sequencer with its AHB-Lite register slave
module fsbs_sequencer #(
  parameter int CYC_PER_MS = fsbs_pkg::FSBS_CYC_PER_MS
) (
  input  wire logic                     MCLK,
  input  wire logic                     NRST,
  input  fsbs_pkg::fsbs_ahb_req_type    AHB_REQ,
  output logic [31:0]                   HRDATA,
  output logic                          HREADYOUT,
  output logic                          HRESP,
  input  wire logic                     FORCED_STOP_INPUT,
  input  wire logic                     ALARM_IN,
  input  wire logic                     NET_LOST,
  input  wire logic                     SERVO_ON,
  input  wire logic                     READY_ON,
  input  wire logic                     STO_IN,
  input  wire logic [15:0]              MOTOR_SPEED,
  output fsbs_pkg::fsbs_drive_type      DRIVE,
  output logic [15:0]                   SPEED_CMD,
  output logic                          SPEED_CMD_ACTIVE,
  output logic [15:0]                   LIFT_AMOUNT,
  output logic                          ZERO_SPEED_FLAG,
  output logic                          SAFE_TORQUE_TIMING_ERROR
);
  import fsbs_pkg::*;

  // registers written by software
  logic [15:0]     ctrl_reg;
  logic [15:0]     decel_reg;
  logic [15:0]     zspd_reg;
  logic [15:0]     delay_reg;
  logic [15:0]     comp_reg;

  // bus data phase
  logic            wr_pend_reg;
  logic [7:0]      wr_addr_reg;
  logic [31:0]     rdata_reg;
  logic            addr_phase;

  // sequencer
  fsbs_state_type  state_reg;
  fsbs_state_type  state_next;
  logic [15:0]     cmd_reg;
  logic [39:0]     acc_reg;
  logic [31:0]     pre_reg;
  logic [15:0]     ms_reg;
  logic            sto_err_reg;
  fsbs_drive_type  drive_reg;
  fsbs_drive_type  drive_next;

  logic            zero_flag;
  logic            trigger;
  logic            link_ok;
  logic            decel_en;
  logic            decel_off;
  logic            torque_mode;
  logic            freefall_ok;
  logic            ramp_done;
  logic            ms_tick;
  logic            sto_clear;
  logic [39:0]     acc_limit;
  logic [39:0]     acc_sum;

  fsbs_zero_speed u_zero (
    .MCLK            (MCLK),
    .NRST            (NRST),
    .MOTOR_SPEED     (MOTOR_SPEED),
    .THRESHOLD       (zspd_reg),
    .ZERO_SPEED_FLAG (zero_flag)
  );

  // ---------------------------------------------------------------- bus slave
  // zero wait states: read data are latched during the address phase
  assign addr_phase = AHB_REQ.hsel && AHB_REQ.hready && AHB_REQ.htrans == FSBS_HTRANS_NONSEQ;
  assign HREADYOUT  = 1'b1;
  assign HRESP      = 1'b0;
  assign HRDATA     = rdata_reg;

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_phase && AHB_REQ.hwrite;
      wr_addr_reg <= AHB_REQ.haddr[7:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      rdata_reg <= 32'h00000000;
    end else if (addr_phase && !AHB_REQ.hwrite) begin
      if (AHB_REQ.haddr[7:0] == FSBS_CTRL_OFS) begin
        rdata_reg <= {16'h0000, ctrl_reg};
      end else if (AHB_REQ.haddr[7:0] == FSBS_DECEL_OFS) begin
        rdata_reg <= {16'h0000, decel_reg};
      end else if (AHB_REQ.haddr[7:0] == FSBS_ZSPD_OFS) begin
        rdata_reg <= {16'h0000, zspd_reg};
      end else if (AHB_REQ.haddr[7:0] == FSBS_DELAY_OFS) begin
        rdata_reg <= {16'h0000, delay_reg};
      end else if (AHB_REQ.haddr[7:0] == FSBS_COMP_OFS) begin
        rdata_reg <= {16'h0000, comp_reg};
      end else if (AHB_REQ.haddr[7:0] == FSBS_STATUS_OFS) begin
        rdata_reg <= {25'h0000000, state_reg, 1'b0, drive_reg.forced_stop_warning,
                      zero_flag, sto_err_reg};
      end else if (AHB_REQ.haddr[7:0] == FSBS_SPEED_OFS) begin
        rdata_reg <= {15'h0000, SPEED_CMD_ACTIVE, cmd_reg};
      end else begin
        rdata_reg <= 32'h00000000;
      end
    end
  end

  // comp_reg holds the freefall compensation amount, zero disables it
  // zspd_reg holds the programmable zero speed threshold
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      ctrl_reg  <= FSBS_CTRL_RST;
      decel_reg <= FSBS_DECEL_RST;
      zspd_reg  <= FSBS_ZSPD_RST;
      delay_reg <= FSBS_DELAY_RST;
      comp_reg  <= FSBS_COMP_RST;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == FSBS_CTRL_OFS) begin
        ctrl_reg <= AHB_REQ.hwdata[15:0];
      end else if (wr_addr_reg == FSBS_DECEL_OFS) begin
        decel_reg <= AHB_REQ.hwdata[15:0];
      end else if (wr_addr_reg == FSBS_ZSPD_OFS) begin
        zspd_reg <= AHB_REQ.hwdata[15:0];
      end else if (wr_addr_reg == FSBS_DELAY_OFS) begin
        delay_reg <= AHB_REQ.hwdata[15:0];
      end else if (wr_addr_reg == FSBS_COMP_OFS) begin
        comp_reg <= AHB_REQ.hwdata[15:0];
      end
    end
  end

  assign sto_clear = wr_pend_reg && wr_addr_reg == FSBS_STATUS_OFS
                     && AHB_REQ.hwdata[FSBS_ST_STOERR];

  // ------------------------------------------------------------ trigger decode
  // network loss and alarm trigger like the forced stop input
  assign trigger     = !FORCED_STOP_INPUT || ALARM_IN || NET_LOST;
  assign link_ok     = SERVO_ON && READY_ON;
  assign decel_en    = ctrl_reg[FSBS_CTRL_MODE_LSB +: 4] == FSBS_MODE_DECEL;
  assign decel_off   = !decel_en;
  assign torque_mode = ctrl_reg[FSBS_CTRL_TORQUE];
  // nonzero amount, trigger at zero speed, delay function on
  assign freefall_ok = comp_reg != 16'h0000 && zero_flag && delay_reg != 16'h0000;
  assign ramp_done   = cmd_reg == 16'h0000 && zero_flag;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FSBS_RUN: begin
        if (trigger) begin
          // without servo-on and ready-on go straight to shut-off
          if (!link_ok) begin
            state_next = FSBS_SHUT;
          // deceleration disabled stops by dynamic brake at once
          end else if (decel_off) begin
            state_next = FSBS_SHUT;
          end else if (freefall_ok) begin
            state_next = FSBS_LIFT;
          // torque mode skips the ramp but keeps the delay
          end else if (torque_mode) begin
            state_next = FSBS_HOLD;
          end else begin
            state_next = FSBS_RAMP;
          end
        end
      end
      FSBS_RAMP: begin
        if (!STO_IN || !link_ok) begin
          state_next = FSBS_SHUT;
        // ramp complete and speed at zero
        end else if (ramp_done) begin
          state_next = FSBS_HOLD;
        end
      end
      FSBS_LIFT: begin
        state_next = link_ok ? FSBS_HOLD : FSBS_SHUT;
      end
      FSBS_HOLD: begin
        if (!link_ok || ms_reg >= delay_reg) begin
          state_next = FSBS_SHUT;
        end
      end
      FSBS_SHUT: begin
        // restart only once every trigger has cleared
        if (!trigger && link_ok) begin
          state_next = FSBS_RUN;
        end
      end
      default: begin
        state_next = FSBS_SHUT;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      state_reg <= FSBS_SHUT;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------ linear ramp
  // rated speed is added each clock; one r/min step when the sum
  // passes time constant times cycles per ms, so rated speed falls in T ms
  assign acc_limit = 40'(decel_reg) * 40'(CYC_PER_MS);
  assign acc_sum   = acc_reg + 40'(FSBS_RATED_SPEED);

  // the command starts from the measured speed and falls to zero
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      cmd_reg <= 16'h0000;
      acc_reg <= 40'h0000000000;
    end else if (state_reg == FSBS_RUN) begin
      cmd_reg <= MOTOR_SPEED;
      acc_reg <= 40'h0000000000;
    end else if (state_reg == FSBS_RAMP && cmd_reg != 16'h0000) begin
      if (acc_sum >= acc_limit) begin
        acc_reg <= acc_sum - acc_limit;
        cmd_reg <= cmd_reg[15] ? cmd_reg + 16'h0001 : cmd_reg - 16'h0001;
      end else begin
        acc_reg <= acc_sum;
      end
    end else if (state_reg != FSBS_RAMP) begin
      cmd_reg <= 16'h0000;
      acc_reg <= 40'h0000000000;
    end
  end

  // ------------------------------------------------------------ delay timer
  assign ms_tick = pre_reg == 32'(CYC_PER_MS - 1);

  // millisecond count from brake interlock drop to shut-off
  always_ff @(posedge MCLK) begin
    if (!NRST || state_reg != FSBS_HOLD) begin
      pre_reg <= 32'h00000000;
      ms_reg  <= 16'h0000;
    end else if (ms_tick) begin
      pre_reg <= 32'h00000000;
      ms_reg  <= ms_reg + 16'h0001;
    end else begin
      pre_reg <= pre_reg + 32'h00000001;
    end
  end

  // safe torque off during the ramp; a new error wins over a clear
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      sto_err_reg <= 1'b0;
    end else if (state_reg == FSBS_RAMP && !STO_IN) begin
      sto_err_reg <= 1'b1;
    end else if (sto_clear) begin
      sto_err_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------ drive outputs
  always_comb begin
    drive_next.brake_interlock_output = state_next == FSBS_RUN || state_next == FSBS_RAMP
                                        || state_next == FSBS_LIFT;
    drive_next.base_power_on          = state_next != FSBS_SHUT;
    drive_next.dynamic_brake_on       = state_next == FSBS_SHUT;
    // warning for the whole sequence while the forced stop input is off
    drive_next.forced_stop_warning    = state_next != FSBS_RUN && !FORCED_STOP_INPUT;
    // lift request before the power stage is cut
    drive_next.lift_request           = state_next == FSBS_LIFT;
  end

  // power stage starts shut off until the first clean run
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      drive_reg <= '{brake_interlock_output: 1'b0, base_power_on: 1'b0,
                     dynamic_brake_on: 1'b1, forced_stop_warning: 1'b0,
                     lift_request: 1'b0};
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign DRIVE                    = drive_reg;
  assign SPEED_CMD                = cmd_reg;
  assign SPEED_CMD_ACTIVE         = state_reg == FSBS_RAMP;
  assign LIFT_AMOUNT              = comp_reg;
  assign ZERO_SPEED_FLAG          = zero_flag;
  assign SAFE_TORQUE_TIMING_ERROR = sto_err_reg;

  // ------------------------------------------------------------ checks
  ramp_entry_a : assert property (@(posedge MCLK) disable iff (!NRST)
    (state_reg == FSBS_RUN && trigger && link_ok && decel_en && !torque_mode && !freefall_ok)
      |=> state_reg == FSBS_RAMP && DRIVE.brake_interlock_output && DRIVE.base_power_on)
    else $error("forced stop did not start the ramp");

  ramp_done_a : assert property (@(posedge MCLK) disable iff (!NRST)
    (state_reg == FSBS_RAMP && STO_IN && link_ok && ramp_done)
      |=> state_reg == FSBS_HOLD ##0 !DRIVE.brake_interlock_output && DRIVE.base_power_on)
    else $error("finished ramp did not drop the brake interlock");

  warn_seq_a : assert property (@(posedge MCLK) disable iff (!NRST)
    (state_reg != FSBS_RUN && !FORCED_STOP_INPUT && $past(!FORCED_STOP_INPUT && NRST))
      |-> DRIVE.forced_stop_warning)
    else $error("forced stop warning missing during sequence");

  torque_skip_a : assert property (@(posedge MCLK) disable iff (!NRST)
    (state_reg == FSBS_RUN && torque_mode) |=> state_reg != FSBS_RAMP)
    else $error("ramp entered in torque mode");

  link_off_a : assert property (@(posedge MCLK) disable iff (!NRST)
    (state_reg != FSBS_SHUT && !link_ok && (trigger || state_reg != FSBS_RUN))
      |=> state_reg == FSBS_SHUT && DRIVE.dynamic_brake_on && !DRIVE.base_power_on)
    else $error("sequence continued without servo-on and ready-on");

  delay_end_a : assert property (@(posedge MCLK) disable iff (!NRST)
    (state_reg == FSBS_HOLD && link_ok && ms_reg < delay_reg) |=> DRIVE.base_power_on
      && !DRIVE.brake_interlock_output)
    else $error("base circuit cut before shut-off delay");

  lift_gate_a : assert property (@(posedge MCLK) disable iff (!NRST)
    $rose(DRIVE.lift_request) |-> $past(comp_reg != 16'h0000 && delay_reg != 16'h0000
      && zero_flag))
    else $error("lift requested without amount or delay");

  lift_pulse_a : assert property (@(posedge MCLK) disable iff (!NRST)
    (DRIVE.lift_request && link_ok) |=> !DRIVE.lift_request ##0 DRIVE.base_power_on)
    else $error("lift request not a single pulse before shut-off");

  alarm_db_a : assert property (@(posedge MCLK) disable iff (!NRST)
    (state_reg == FSBS_RUN && ALARM_IN && decel_off) |=> state_reg == FSBS_SHUT)
    else $error("alarm with deceleration disabled did not brake at once");

  sto_error_a : assert property (@(posedge MCLK) disable iff (!NRST)
    (state_reg == FSBS_RAMP && !STO_IN) |=> SAFE_TORQUE_TIMING_ERROR && state_reg == FSBS_SHUT)
    else $error("safe torque off during ramp not flagged");

endmodule : fsbs_sequencer

/* src/fsbs_zero_speed.sv */
// zero speed detector with hysteresis
module fsbs_zero_speed (
  input  wire logic        MCLK,
  input  wire logic        NRST,
  input  wire logic [15:0] MOTOR_SPEED,
  input  wire logic [15:0] THRESHOLD,
  output logic             ZERO_SPEED_FLAG
);
  import fsbs_pkg::*;

  logic [15:0] speed_abs;
  logic [16:0] off_level;
  logic        zero_reg;

  assign speed_abs = MOTOR_SPEED[15] ? 16'(-MOTOR_SPEED) : MOTOR_SPEED;
  assign off_level = {1'b0, THRESHOLD} + {1'b0, FSBS_ZSPD_HYST};

  // on at threshold, off above threshold plus hysteresis
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      zero_reg <= 1'b1;
    end else if (speed_abs <= THRESHOLD) begin
      zero_reg <= 1'b1;
    end else if ({1'b0, speed_abs} > off_level) begin
      zero_reg <= 1'b0;
    end
  end

  assign ZERO_SPEED_FLAG = zero_reg;

  zero_on_a : assert property (@(posedge MCLK) disable iff (!NRST)
    speed_abs <= THRESHOLD |=> ZERO_SPEED_FLAG)
    else $error("zero speed flag not set at threshold");

  zero_off_a : assert property (@(posedge MCLK) disable iff (!NRST)
    {1'b0, speed_abs} > off_level |=> !ZERO_SPEED_FLAG)
    else $error("zero speed flag not cleared above off level");

  zero_hold_a : assert property (@(posedge MCLK) disable iff (!NRST)
    (speed_abs > THRESHOLD && {1'b0, speed_abs} <= off_level && $stable(THRESHOLD))
      |=> ZERO_SPEED_FLAG == $past(ZERO_SPEED_FLAG))
    else $error("zero speed flag moved inside hysteresis band");

endmodule : fsbs_zero_speed

/* tb/fsbs_motor_model.sv */
// servo motor and controller link model facing the sequencer
module fsbs_motor_model (
  input  wire logic               mclk,
  input  fsbs_pkg::fsbs_drive_type drive,
  input  wire logic [15:0]        speed_cmd,
  input  wire logic               speed_cmd_active,
  input  wire logic [15:0]        target_speed,
  input  wire logic               link_ok,
  output logic                    servo_on,
  output logic                    ready_on,
  output logic [15:0]             motor_speed
);
  timeunit 1ns;
  timeprecision 100ps;
  import fsbs_pkg::*;
  // controller holds both commands, never toggles the stop input itself
  assign servo_on = link_ok;
  assign ready_on = link_ok;
  initial motor_speed = 16'h0000;
  // motor tracks the ramp, is held by the brake once the interlock drops
  always @(posedge mclk) begin
    if (speed_cmd_active) begin
      motor_speed <= speed_cmd;
    end else if (!drive.base_power_on) begin
      motor_speed <= 16'h0000;
    end else if (drive.brake_interlock_output) begin
      motor_speed <= target_speed;
    end
  end
endmodule : fsbs_motor_model

/* tb/fsbs_sequencer_test.sv */
// self-checking bench of the forced stop brake sequencer
module fsbs_sequencer_test;
  timeunit 1ns;
  timeprecision 100ps;
  import fsbs_pkg::*;
  logic             mclk, nrst, fsi, alarm, net_lost, sto, link_ok, hsel, hwrite;
  logic             hreadyout, hresp, servo_on, ready_on, cmd_active, zero_flag, sto_err;
  logic [31:0]      haddr, hwdata, hrdata, rd;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [15:0]      target, speed, speed_cmd, lift_amount;
  fsbs_ahb_req_type ahb_req;
  fsbs_drive_type   drive;
  int               mismatches = 0, cmp_count = 0, cycles = 0, n, seen;
  logic [7:0]       row_adr [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
  // status idle while running; speed word mirrors the measured speed in run
  logic [15:0]      row_exp [8] = '{16'h2000, 16'h0064, 16'h0032, 16'h0000, 16'h0000, 16'h0000,
                                    16'h0064, 16'h0000};
  logic [15:0]      hy_spd [6] = '{16'h0064, 16'h003c, 16'h0032, 16'h003c, 16'h0046, 16'h0047};
  logic             hy_exp [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

  assign ahb_req = {hsel, haddr, htrans, hwrite, hsize, hreadyout, hwdata};
  always #2 mclk = ~mclk;

  // ten clocks per ms keeps the delays short
  fsbs_sequencer #(.CYC_PER_MS(10)) i_dut (
    .MCLK(mclk), .NRST(nrst), .AHB_REQ(ahb_req), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .FORCED_STOP_INPUT(fsi), .ALARM_IN(alarm), .NET_LOST(net_lost),
    .SERVO_ON(servo_on), .READY_ON(ready_on), .STO_IN(sto), .MOTOR_SPEED(speed),
    .DRIVE(drive), .SPEED_CMD(speed_cmd), .SPEED_CMD_ACTIVE(cmd_active),
    .LIFT_AMOUNT(lift_amount), .ZERO_SPEED_FLAG(zero_flag),
    .SAFE_TORQUE_TIMING_ERROR(sto_err));
  fsbs_motor_model i_motor (
    .mclk(mclk), .drive(drive), .speed_cmd(speed_cmd), .speed_cmd_active(cmd_active),
    .target_speed(target), .link_ok(link_ok), .servo_on(servo_on), .ready_on(ready_on),
    .motor_speed(speed));

  task automatic check_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // entered just after a rising edge; single word transfer
  task automatic ahb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, adr};
    htrans <= FSBS_HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask : ahb

  task automatic wait_run();
    for (n = 0; n < 500 && !(drive.base_power_on === 1'b1
         && drive.brake_interlock_output === 1'b1); n++) @(posedge mclk);
    repeat (4) @(posedge mclk);
  endtask : wait_run

  task automatic set_trig(input int t, input logic on);
    fsi      <= !(on && t == 0);
    alarm    <= on && t == 1;
    net_lost <= on && t == 2;
  endtask : set_trig

  task automatic wait_shut();
    for (n = 0; n < 400 && drive.base_power_on === 1'b1; n++) @(posedge mclk);
  endtask : wait_shut

  task automatic stop_case(input int t);
    wait_run();
    set_trig(t, 1'b1);
    repeat (2) @(posedge mclk);
    check_bit(cmd_active, 1'b1);
    check_bit(drive.forced_stop_warning, t == 0);
    for (n = 2; n < 400 && cmd_active === 1'b1; n++) @(posedge mclk);
    // 100 r/min at 600 ms per 3000 r/min is 20 ms, 200 clocks
    check_bit(n >= 198 && n <= 206, 1'b1);
    check_word({16'h0000, speed_cmd}, 32'h0);
    check_bit(drive.brake_interlock_output, 1'b0);
    wait_shut();
    check_bit(n >= 18 && n <= 23, 1'b1);
    check_bit(drive.dynamic_brake_on, 1'b1);
    set_trig(t, 1'b0);
  endtask : stop_case

  task automatic quick_case(input logic [31:0] ctrl, input int t, input logic lk,
                            input logic exp_base);
    ahb(1'b1, FSBS_CTRL_OFS, ctrl);
    wait_run();
    link_ok <= lk;
    set_trig(t, 1'b1);
    repeat (3) @(posedge mclk);
    check_bit(cmd_active, 1'b0);
    check_bit(drive.base_power_on, exp_base);
    check_bit(drive.dynamic_brake_on, !exp_base);
    wait_shut();
    link_ok <= 1'b1;
    set_trig(t, 1'b0);
    ahb(1'b1, FSBS_CTRL_OFS, 32'h2000);
  endtask : quick_case

  task automatic ff_case(input logic [31:0] comp, dly, spd, input logic exp);
    ahb(1'b1, FSBS_COMP_OFS, comp);
    ahb(1'b1, FSBS_DELAY_OFS, dly);
    target <= spd[15:0];
    wait_run();
    set_trig(0, 1'b1);
    seen = 0;
    repeat (4) begin
      @(posedge mclk);
      if (drive.lift_request === 1'b1 && drive.base_power_on === 1'b1) seen++;
    end
    check_bit(seen != 0, exp);
    check_word({16'h0000, lift_amount}, comp);
    wait_shut();
    set_trig(0, 1'b0);
  endtask : ff_case

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    mclk = 1'b0; nrst = 1'b0; fsi = 1'b1; alarm = 1'b0; net_lost = 1'b0; sto = 1'b1;
    link_ok = 1'b1; target = 16'h0064; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    repeat (9) @(posedge mclk);
    check_bit(drive.base_power_on, 1'b0);
    @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    ahb(1'b1, 8'h1c, 32'hffffffff);
    for (int i = 0; i < 8; i++) begin
      ahb(1'b0, row_adr[i], 32'h0);
      check_word(rd, {16'h0000, row_exp[i]});
      check_bit(hresp, 1'b0);
    end
    ahb(1'b1, FSBS_DECEL_OFS, 32'h0258);
    // delay set with margin over the brake's own delay
    ahb(1'b1, FSBS_DELAY_OFS, 32'h2);
    for (int t = 0; t < 3; t++) stop_case(t);
    quick_case(32'h2001, 0, 1'b1, 1'b1);
    quick_case(32'h2000, 1, 1'b0, 1'b0);
    quick_case(32'h0000, 1, 1'b1, 1'b0);
    ff_case(32'h5, 32'h2, 32'h0, 1'b1);
    ff_case(32'h5, 32'h0, 32'h0, 1'b0);
    ff_case(32'h0, 32'h2, 32'h0, 1'b0);
    ff_case(32'h5, 32'h2, 32'h64, 1'b0);
    wait_run();
    fsi <= 1'b0;
    repeat (10) @(posedge mclk);
    sto <= 1'b0;
    repeat (3) @(posedge mclk);
    check_bit(sto_err, 1'b1);
    check_bit(drive.base_power_on, 1'b0);
    sto <= 1'b1;
    fsi <= 1'b1;
    ahb(1'b1, FSBS_STATUS_OFS, 32'h1);
    ahb(1'b0, FSBS_STATUS_OFS, 32'h0);
    check_bit(rd[FSBS_ST_STOERR], 1'b0);
    wait_run();
    for (int i = 0; i < 6; i++) begin
      target <= hy_spd[i];
      repeat (4) @(posedge mclk);
      check_bit(zero_flag, hy_exp[i]);
    end
    // reset in mid-run: power stage shut and the compensation register back to its reset value
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    check_bit(drive.dynamic_brake_on, 1'b1);
    check_bit(drive.base_power_on, 1'b0);
    ahb(1'b0, FSBS_COMP_OFS, 32'h0);
    check_word(rd, 32'h0);
    final_report();
  end
endmodule : fsbs_sequencer_test
